//--- include/utrb_pkg.sv
// Purpose: shared constants and types for the serial transmit/receive core
// Assumes: 32-bit AXI4-Lite register access, one aligned word per register
// Notes:   offsets are byte addresses; data sits in the low byte
package utrb_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam int          ADDR_W       = 5;
  localparam logic [4:0]  OFF_DATA     = 5'h00;  // write: holding, read: buffer
  localparam logic [4:0]  OFF_LINE_CTL = 5'h04;
  localparam logic [4:0]  OFF_LINE_STS = 5'h08;
  localparam logic [4:0]  OFF_DIV_LOW  = 5'h0c;
  localparam logic [4:0]  OFF_DIV_HIGH = 5'h10;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // ****************************************
  // reset values and field positions
  // ****************************************
  localparam logic [7:0]  LCR_RESET    = 8'h00;
  localparam logic [15:0] DIV_RESET    = 16'h0001;
  localparam int          LCR_USED_MSB = 4;      // bits above read zero

  // ****************************************
  // bit timing in 16x ticks
  // ****************************************
  localparam logic [4:0]  TICK_MID     = 5'h07;  // start-bit centre, 7.5 ticks
  localparam logic [4:0]  TICK_BIT     = 5'h0f;  // last tick of a bit cell
  localparam logic [4:0]  TICK_STOP1   = 5'h0f;  // one stop bit
  localparam logic [4:0]  TICK_STOP15  = 5'h17;  // one and a half stop bits
  localparam logic [4:0]  TICK_STOP2   = 5'h1f;  // two stop bits

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic [2:0] unused;
    logic       par_even;   // bit 4
    logic       par_en;     // bit 3
    logic       stop_long;  // bit 2
    logic [1:0] word_len;   // bits 1:0, 00..11 = 5..8 bits
  } utrb_lcr_t;

  typedef struct packed {
    logic       zero7;
    logic       tx_all_empty;      // bit 6
    logic       tx_holding_empty;  // bit 5
    logic       brk;               // bit 4, not detected here
    logic       frame_err;         // bit 3
    logic       par_err;           // bit 2
    logic       overrun;           // bit 1
    logic       data_ready;        // bit 0
  } utrb_lsr_t;

  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP} utrb_state_t;
endpackage

//--- core/utrb_core.sv
// Purpose: asynchronous serial transmitter/receiver with 16-bit rate divisor
// Assumes: i_serial_in synchronous to i_mclk; AXI4-Lite master, one op each way
// Notes:   rate_generator emits a one-cycle 16x tick enable every divisor cycles
`timescale 1ns/1ns
module utrb_core #(
  parameter int DIV_W = 16                        // divisor width
) (
  input  wire logic                       i_mclk,          // 250 MHz clock
  input  wire logic                       i_rstn,          // sync reset, low
  input  wire logic [utrb_pkg::ADDR_W-1:0] i_awaddr,       // write address
  input  wire logic                       i_awvalid,       // write address valid
  output      logic                       o_awready,       // write address ready
  input  wire logic [31:0]                i_wdata,         // write data
  input  wire logic [3:0]                 i_wstrb,         // byte enables
  input  wire logic                       i_wvalid,        // write data valid
  output      logic                       o_wready,        // write data ready
  output      logic [1:0]                 o_bresp,         // write response
  output      logic                       o_bvalid,        // write response valid
  input  wire logic                       i_bready,        // write response ready
  input  wire logic [utrb_pkg::ADDR_W-1:0] i_araddr,       // read address
  input  wire logic                       i_arvalid,       // read address valid
  output      logic                       o_arready,       // read address ready
  output      logic [31:0]                o_rdata,         // read data
  output      logic [1:0]                 o_rresp,         // read response
  output      logic                       o_rvalid,        // read data valid
  input  wire logic                       i_rready,        // read data ready
  input  wire logic                       i_serial_in,     // line from peer
  output      logic                       o_serial_out,    // line to peer
  output      logic                       o_sample_clock_out // 16x tick
);
  // ****************************************
  // elaboration check
  // ****************************************
  if (DIV_W < 2 || DIV_W > 16) begin : g_bad_width
    $error("divisor width must be 2 to 16");
  end

  // ****************************************
  // decoding functions
  // ****************************************
  // index of the last data bit, 4..7 for 5..8 bits
  function automatic logic [2:0] last_bit(input utrb_pkg::utrb_lcr_t c);
    last_bit = 3'h4 + {1'b0, c.word_len};
  endfunction

  // last tick of the stop period
  function automatic logic [4:0] stop_last(input utrb_pkg::utrb_lcr_t c);
    if (!c.stop_long) begin
      stop_last = utrb_pkg::TICK_STOP1;
    end else if (c.word_len == 2'h0) begin
      stop_last = utrb_pkg::TICK_STOP15;
    end else begin
      stop_last = utrb_pkg::TICK_STOP2;
    end
  endfunction

  // parity bit for the selected sense
  function automatic logic par_of(input logic [7:0] d, input utrb_pkg::utrb_lcr_t c);
    par_of = (^d) ^ ~c.par_even;
  endfunction

  // ****************************************
  // registers and state
  // ****************************************
  utrb_pkg::utrb_lcr_t   line_control_reg;
  logic [7:0]            divisor_low_byte;
  logic [7:0]            divisor_high_byte;
  logic [7:0]            tx_holding_reg;
  logic [7:0]            tx_shift_reg;
  logic [7:0]            rx_shift_reg;
  logic [7:0]            rx_buffer_reg;
  logic                  hold_full;
  logic                  tx_par;
  logic                  data_ready;
  logic                  overrun;
  logic                  par_err;
  logic                  frame_err;
  utrb_pkg::utrb_state_t tx_st;
  utrb_pkg::utrb_state_t rx_st;
  logic [4:0]            tx_cnt;
  logic [4:0]            rx_cnt;
  logic [2:0]            tx_bit;
  logic [2:0]            rx_bit;
  logic                  rx_prev;
  logic                  rx_par;
  logic [DIV_W-1:0]      rate_cnt;
  logic                  tick;
  logic                  aw_held;
  logic                  w_held;
  logic [utrb_pkg::ADDR_W-1:0] aw_addr;
  logic [7:0]            w_byte;
  logic                  w_lane0;

  // ****************************************
  // rate_generator
  // ****************************************
  wire [15:0]      div_full = {divisor_high_byte, divisor_low_byte};
  wire [DIV_W-1:0] div_val  = div_full[DIV_W-1:0];
  // divisor 0 wraps and acts as the largest divisor
  wire [DIV_W-1:0] div_last = div_val - {{(DIV_W-1){1'b0}}, 1'b1};
  wire             rate_hit = (rate_cnt >= div_last);

  // one tick every divisor clocks, divisor 1 ticks every clock
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      rate_cnt <= '0;
      tick     <= 1'b0;
    end else begin
      rate_cnt <= rate_hit ? '0 : rate_cnt + 1'b1;
      tick     <= rate_hit;
    end
  end
  assign o_sample_clock_out = tick;

  // ****************************************
  // register bus decode
  // ****************************************
  wire do_write  = aw_held && w_held && !o_bvalid;
  wire ar_take   = i_arvalid && o_arready;
  wire wr_data   = do_write && w_lane0 && (aw_addr == utrb_pkg::OFF_DATA);
  wire wr_lcr    = do_write && w_lane0 && (aw_addr == utrb_pkg::OFF_LINE_CTL);
  wire wr_dll    = do_write && w_lane0 && (aw_addr == utrb_pkg::OFF_DIV_LOW);
  wire wr_dlm    = do_write && w_lane0 && (aw_addr == utrb_pkg::OFF_DIV_HIGH);
  wire wr_map    = (aw_addr == utrb_pkg::OFF_DATA) || (aw_addr == utrb_pkg::OFF_LINE_CTL)
                || (aw_addr == utrb_pkg::OFF_DIV_LOW) || (aw_addr == utrb_pkg::OFF_DIV_HIGH)
                || (aw_addr == utrb_pkg::OFF_LINE_STS);
  wire rd_data   = ar_take && (i_araddr == utrb_pkg::OFF_DATA);
  wire rd_lsr    = ar_take && (i_araddr == utrb_pkg::OFF_LINE_STS);
  assign o_awready = !aw_held && !o_bvalid;
  assign o_wready  = !w_held && !o_bvalid;
  assign o_arready = !o_rvalid;

  // status view of the live flags
  wire tx_idle = (tx_st == utrb_pkg::ST_IDLE);
  wire all_empty = tx_idle && !hold_full;
  utrb_pkg::utrb_lsr_t lsr_view;
  assign lsr_view = '{zero7: 1'b0, tx_all_empty: all_empty,
                      tx_holding_empty: !hold_full, brk: 1'b0,
                      frame_err: frame_err, par_err: par_err,
                      overrun: overrun, data_ready: data_ready};
  wire [7:0] lcr_view = {3'h0, line_control_reg[utrb_pkg::LCR_USED_MSB:0]};

  // read data selection
  logic [7:0] rd_byte;
  logic       rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    unique case (i_araddr)
      utrb_pkg::OFF_DATA:     rd_byte = rx_buffer_reg;
      utrb_pkg::OFF_LINE_CTL: rd_byte = lcr_view;
      utrb_pkg::OFF_LINE_STS: rd_byte = lsr_view;
      utrb_pkg::OFF_DIV_LOW:  rd_byte = divisor_low_byte;
      utrb_pkg::OFF_DIV_HIGH: rd_byte = divisor_high_byte;
      default: begin
        rd_byte = 8'h00;
        rd_ok   = 1'b0;
      end
    endcase
  end

  // write channels held independently, response once both are in
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      aw_held  <= 1'b0;
      w_held   <= 1'b0;
      aw_addr  <= '0;
      w_byte   <= 8'h00;
      w_lane0  <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp  <= utrb_pkg::RESP_OKAY;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_held <= 1'b1;
        aw_addr <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_held  <= 1'b1;
        w_byte  <= i_wdata[7:0];
        w_lane0 <= i_wstrb[0];
      end
      if (do_write) begin
        aw_held  <= 1'b0;
        w_held   <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp  <= wr_map ? utrb_pkg::RESP_OKAY : utrb_pkg::RESP_SLVERR;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      o_rvalid <= 1'b0;
      o_rdata  <= 32'h0000_0000;
      o_rresp  <= utrb_pkg::RESP_OKAY;
    end else if (ar_take) begin
      o_rvalid <= 1'b1;
      o_rdata  <= {24'h00_0000, rd_byte};
      o_rresp  <= rd_ok ? utrb_pkg::RESP_OKAY : utrb_pkg::RESP_SLVERR;
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

  localparam logic [7:0] DIV_RESET_LOW  = utrb_pkg::DIV_RESET[7:0];
  localparam logic [7:0] DIV_RESET_HIGH = utrb_pkg::DIV_RESET[15:8];

  // control registers; divisor kept across reset would need no reset here,
  // but a known divide-by-one start is safer for bring-up
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      line_control_reg  <= utrb_pkg::LCR_RESET;
      divisor_low_byte  <= DIV_RESET_LOW;
      divisor_high_byte <= DIV_RESET_HIGH;
    end else begin
      if (wr_lcr) line_control_reg  <= w_byte;
      if (wr_dll) divisor_low_byte  <= w_byte;
      if (wr_dlm) divisor_high_byte <= w_byte;
    end
  end

  // ****************************************
  // transmitter
  // ****************************************
  wire tx_load = tick && tx_idle && hold_full;
  wire tx_cell = tick && (tx_cnt == utrb_pkg::TICK_BIT);
  wire tx_stop_end = tick && (tx_cnt == stop_last(line_control_reg));
  // data mask for the configured length
  wire [7:0] len_mask = 8'hff >> (3'h7 - last_bit(line_control_reg));

  // holding register; a write in the load cycle wins over the transfer
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      hold_full <= 1'b0;
    end else if (wr_data) begin
      hold_full <= 1'b1;
    end else if (tx_load) begin
      hold_full <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (wr_data) tx_holding_reg <= w_byte;
  end

  // shifter sequence, one state per field
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      tx_st  <= utrb_pkg::ST_IDLE;
      tx_cnt <= 5'h00;
      tx_bit <= 3'h0;
      tx_shift_reg <= 8'h00;
      tx_par <= 1'b0;
    end else if (tick) begin
      tx_cnt <= tx_cnt + 5'h01;
      unique case (tx_st)
        utrb_pkg::ST_IDLE: begin
          tx_cnt <= 5'h00;
          if (hold_full) begin
            tx_shift_reg <= tx_holding_reg;
            tx_par <= par_of(tx_holding_reg & len_mask, line_control_reg);
            tx_st  <= utrb_pkg::ST_START;
          end
        end
        utrb_pkg::ST_START: if (tx_cell) begin
          tx_st  <= utrb_pkg::ST_DATA;
          tx_cnt <= 5'h00;
          tx_bit <= 3'h0;
        end
        utrb_pkg::ST_DATA: if (tx_cell) begin
          tx_cnt <= 5'h00;
          tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
          tx_bit <= tx_bit + 3'h1;
          if (tx_bit == last_bit(line_control_reg)) begin
            tx_st <= line_control_reg.par_en ? utrb_pkg::ST_PAR : utrb_pkg::ST_STOP;
          end
        end
        utrb_pkg::ST_PAR: if (tx_cell) begin
          tx_st  <= utrb_pkg::ST_STOP;
          tx_cnt <= 5'h00;
        end
        utrb_pkg::ST_STOP: if (tx_stop_end) begin
          tx_st <= utrb_pkg::ST_IDLE;
        end
        default: tx_st <= utrb_pkg::ST_IDLE;
      endcase
    end
  end

  // line level per state, registered onto the pin
  logic next_serial_out;
  always_comb begin
    unique case (tx_st)
      utrb_pkg::ST_START: next_serial_out = 1'b0;
      utrb_pkg::ST_DATA:  next_serial_out = tx_shift_reg[0];
      utrb_pkg::ST_PAR:   next_serial_out = tx_par;
      default:            next_serial_out = 1'b1;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) o_serial_out <= 1'b1;
    else o_serial_out <= next_serial_out;
  end

  // ****************************************
  // receiver
  // ****************************************
  wire rx_edge   = rx_prev && !i_serial_in;
  wire rx_cell   = tick && (rx_cnt == utrb_pkg::TICK_BIT);
  wire rx_centre = tick && (rx_cnt == utrb_pkg::TICK_MID);
  wire rx_done   = rx_cell && (rx_st == utrb_pkg::ST_STOP);
  wire [7:0] rx_word = rx_shift_reg >> (3'h7 - last_bit(line_control_reg));
  wire par_bad   = line_control_reg.par_en && (rx_par != par_of(rx_word, line_control_reg));

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      rx_st   <= utrb_pkg::ST_IDLE;
      rx_prev <= 1'b1;
      rx_cnt  <= 5'h00;
      rx_bit  <= 3'h0;
      rx_par  <= 1'b0;
      rx_shift_reg <= 8'h00;
    end else begin
      rx_prev <= i_serial_in;
      if (tick) rx_cnt <= rx_cnt + 5'h01;
      unique case (rx_st)
        utrb_pkg::ST_IDLE: if (rx_edge) begin
          rx_st  <= utrb_pkg::ST_START;
          rx_cnt <= 5'h00;
        end
        utrb_pkg::ST_START: if (rx_centre) begin
          rx_cnt <= 5'h00;
          rx_bit <= 3'h0;
          rx_st  <= i_serial_in ? utrb_pkg::ST_IDLE : utrb_pkg::ST_DATA;
        end
        utrb_pkg::ST_DATA: if (rx_cell) begin
          rx_cnt <= 5'h00;                              // restart the cell count
          rx_shift_reg <= {i_serial_in, rx_shift_reg[7:1]};
          rx_bit <= rx_bit + 3'h1;
          if (rx_bit == last_bit(line_control_reg)) begin
            rx_st <= line_control_reg.par_en ? utrb_pkg::ST_PAR : utrb_pkg::ST_STOP;
          end
        end
        utrb_pkg::ST_PAR: if (rx_cell) begin
          rx_cnt <= 5'h00;
          rx_par <= i_serial_in;
          rx_st  <= utrb_pkg::ST_STOP;
        end
        utrb_pkg::ST_STOP: if (rx_cell) begin
          rx_st <= utrb_pkg::ST_IDLE;
        end
        default: rx_st <= utrb_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (rx_done) rx_buffer_reg <= rx_word;
  end

  // status flags; a hardware set wins over the read that clears it
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      data_ready <= 1'b0;
      overrun    <= 1'b0;
      par_err    <= 1'b0;
      frame_err  <= 1'b0;
    end else begin
      if (rx_done) data_ready <= 1'b1;
      else if (rd_data) data_ready <= 1'b0;
      if (rx_done && data_ready && !rd_data) overrun <= 1'b1;
      else if (rd_lsr) overrun <= 1'b0;
      if (rx_done && par_bad) par_err <= 1'b1;
      else if (rd_lsr) par_err <= 1'b0;
      if (rx_done && !i_serial_in) frame_err <= 1'b1;
      else if (rd_lsr) frame_err <= 1'b0;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_write_clears_empty: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    wr_data |=> hold_full) else $error("holding write did not clear empty");
  a_load_at_start: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    tx_load && !wr_data |=> !hold_full && tx_st == utrb_pkg::ST_START ##1 !o_serial_out)
    else $error("load did not start the frame");
  a_shift_busy: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    !o_serial_out |-> !all_empty) else $error("shifter empty while line driven low");
  a_hold_wait: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    hold_full && !tx_idle |=> hold_full) else $error("holding moved while shifter busy");
  a_ready_set: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    rx_done |=> data_ready && rx_st == utrb_pkg::ST_IDLE) else $error("data ready not set");
  a_ready_clear: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    rd_data && !rx_done |=> !data_ready) else $error("buffer read kept data ready");
  a_overrun_set: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    rx_done && data_ready && !rd_data |=> overrun) else $error("overrun not flagged");
  a_noise_reject: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    rx_st == utrb_pkg::ST_START && rx_centre && i_serial_in |=> rx_st == utrb_pkg::ST_IDLE)
    else $error("noise accepted as start");
  a_div_one: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    div_full == 16'h0001 && $stable(div_full) && tick |=> tick) else $error("divide by one slow");
  a_idle_high: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    tx_idle && $past(tx_idle) |=> o_serial_out) else $error("line low while idle");
endmodule

//--- tb/utrb_peer.sv
// Purpose: serial peer that sends frames to the core and captures its frames
// Assumes: bit time given in clocks; line changed just after a rising edge
// Notes:   line idles high; glitch task makes a short low spike
`timescale 1ns/1ns
module utrb_peer (
  input  wire logic i_mclk, // core clock
  input  wire logic i_line, // line from core
  output      logic o_line  // line to core
);
  initial o_line = 1'b1;
  // start low, data lsb first, parity bit par[0] unless par is negative, then stop level
  task automatic send(input logic [7:0] d, input int n, input int bt, input int par,
                      input logic stop);
    o_line <= 1'b0;
    repeat (bt) @(posedge i_mclk);
    for (int i = 0; i < n; i++) begin
      o_line <= d[i];
      repeat (bt) @(posedge i_mclk);
    end
    if (par >= 0) begin
      o_line <= par[0];
      repeat (bt) @(posedge i_mclk);
    end
    o_line <= stop;
    repeat (bt) @(posedge i_mclk);
    o_line <= 1'b1;
    repeat (2 * bt) @(posedge i_mclk);
  endtask
  // short low spike, rejected if shorter than half a bit
  task automatic glitch(input int c);
    o_line <= 1'b0;
    repeat (c) @(posedge i_mclk);
    o_line <= 1'b1;
    // wait longer than a whole frame, so an accepted spike would show
    repeat (200) @(posedge i_mclk);
  endtask
  // sample the core's frame at bit centres; ok needs low start and high stop
  task automatic grab(input int n, input int bt, output logic [7:0] d, output logic ok);
    int w;
    d = 8'h00;
    w = 0;
    while (i_line !== 1'b0 && w < 4000) begin
      @(posedge i_mclk);
      w++;
    end
    repeat (bt / 2) @(posedge i_mclk);
    ok = (i_line === 1'b0);
    for (int i = 0; i < n; i++) begin
      repeat (bt) @(posedge i_mclk);
      d[i] = i_line;
    end
    repeat (bt) @(posedge i_mclk);
    ok = ok && (i_line === 1'b1);
  endtask
endmodule

//--- tb/tb_uart_tx_rx_baud_core.sv
// Purpose: self-checking bench for the serial core over AXI4-Lite
// Assumes: divisor 1 unless a test sets it, so a bit lasts 16 clocks
// Notes:   peer model drives the receive line and captures the transmit line
`timescale 1ns/1ns
module tb_uart_tx_rx_baud_core;
  logic        i_mclk, i_rstn, awv, wv, bready, arv, rready;
  logic [4:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic        awrdy, wrdy, bvalid, arrdy, rvalid, ser_in, ser_out, tick;
  int          fails, checks_done;
  utrb_core u_dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_awaddr(awaddr), .i_awvalid(awv),
    .o_awready(awrdy), .i_wdata(wdata), .i_wstrb(4'hf), .i_wvalid(wv), .o_wready(wrdy),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
    .i_arvalid(arv), .o_arready(arrdy), .o_rdata(rdata), .o_rresp(rresp),
    .o_rvalid(rvalid), .i_rready(rready), .i_serial_in(ser_in), .o_serial_out(ser_out),
    .o_sample_clock_out(tick));
  utrb_peer u_peer (.i_mclk(i_mclk), .i_line(ser_out), .o_line(ser_in));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // bus tasks are entered just after a rising edge
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge i_mclk);
      n++;
      if (awrdy === 1'b1) awv <= 1'b0;
      if (wrdy === 1'b1) wv <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    if (bvalid !== 1'b1) begin
      fails++;
      $display("Error at %0t: write answer timed out", $time);
    end
    chk(bresp, utrb_pkg::RESP_OKAY);
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arv <= 1'b1;
    do begin
      @(posedge i_mclk);
      n++;
      if (arrdy === 1'b1) arv <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    if (rvalid !== 1'b1) begin
      fails++;
      $display("Error at %0t: read answer timed out", $time);
    end
    d = rdata;
    r = rresp;
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [7:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d, {24'h0, exp});
  endtask
  task automatic t_reset;
    rdchk(utrb_pkg::OFF_LINE_STS, 8'h60);
    rdchk(utrb_pkg::OFF_DIV_LOW, 8'h01);
  endtask
  // unused control bits read zero; unmapped place answers with an error
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    wr(utrb_pkg::OFF_LINE_CTL, 8'hff);
    rdchk(utrb_pkg::OFF_LINE_CTL, 8'h1f);
    rd(5'h14, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, {30'h0, utrb_pkg::RESP_SLVERR});
  endtask
  // two characters back to back; second waits in the holding register
  task automatic t_tx;
    logic [7:0] a, b;
    logic       oka, okb;
    wr(utrb_pkg::OFF_LINE_CTL, 8'h03);
    fork
      begin
        u_peer.grab(8, 16, a, oka);
        u_peer.grab(8, 16, b, okb);
      end
      begin
        wr(utrb_pkg::OFF_DATA, 8'ha5);
        rdchk(utrb_pkg::OFF_LINE_STS, 8'h20);
        wr(utrb_pkg::OFF_DATA, 8'h3c);
        rdchk(utrb_pkg::OFF_LINE_STS, 8'h00);
      end
    join
    chk({a, b, 6'h0, oka, okb}, {16'ha53c, 8'h03});
    repeat (40) @(posedge i_mclk);
    rdchk(utrb_pkg::OFF_LINE_STS, 8'h60);
  endtask
  // 7 bits even parity: good frame, two bad unread frames, then a spike
  task automatic t_rx;
    wr(utrb_pkg::OFF_LINE_CTL, 8'h1a);
    u_peer.send(8'h3c, 7, 16, 0, 1'b1);
    rdchk(utrb_pkg::OFF_LINE_STS, 8'h61);
    rdchk(utrb_pkg::OFF_DATA, 8'h3c);
    rdchk(utrb_pkg::OFF_LINE_STS, 8'h60);
    u_peer.send(8'h3c, 7, 16, 1, 1'b0);
    u_peer.send(8'h15, 7, 16, 0, 1'b0);
    rdchk(utrb_pkg::OFF_LINE_STS, 8'h6f);
    rdchk(utrb_pkg::OFF_LINE_STS, 8'h61);
    rdchk(utrb_pkg::OFF_DATA, 8'h15);
    u_peer.glitch(4);
    rdchk(utrb_pkg::OFF_LINE_STS, 8'h60);
  endtask
  // clocks between two 16x ticks must equal the divisor, high byte included
  task automatic t_rate;
    int c;
    logic [15:0] dv;
    for (int i = 0; i < 3; i++) begin
      dv = (i == 0) ? 16'h0180 : (i == 1) ? 16'h0004 : 16'h0001;
      wr(utrb_pkg::OFF_DIV_HIGH, dv[15:8]);
      wr(utrb_pkg::OFF_DIV_LOW, dv[7:0]);
      repeat (8) @(posedge i_mclk);
      c = 0;
      while (tick !== 1'b1 && c < 999) begin
        @(posedge i_mclk);
        c++;
      end
      c = 0;
      do begin
        @(posedge i_mclk);
        c++;
      end while (tick !== 1'b1 && c < 999);
      chk(32'(c), {16'h0, dv});
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d, fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end
  initial begin
    i_rstn = 1'b0;
    {awv, wv, bready, arv, rready} = 5'h05;  // answer readies stay high all run
    {awaddr, araddr, wdata} = '0;
    fails = 0;
    checks_done = 0;
    repeat (2) @(posedge i_mclk);
    i_rstn <= 1'b1;
    @(posedge i_mclk);
    t_reset;
    t_regs;
    t_tx;
    t_rx;
    t_rate;
    report_and_stop;
  end
  // whole run needs a few thousand clocks
  initial begin
    #40000;
    fails++;
    report_and_stop;
  end
endmodule
